/* File: hw/bhc_pkg.sv */
// Constants for the bridge configuration header and command block.
package bhc_pkg;

  // ==========================================================================
  // Configuration offsets
  // ==========================================================================
  localparam logic [7:0] OFS_VENDOR  = 8'h00;
  localparam logic [7:0] OFS_DEVICE  = 8'h02;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h06;

  // ==========================================================================
  // Command word fields
  // ==========================================================================
  localparam int CMD_IO_BIT     = 0;
  localparam int CMD_MEM_BIT    = 1;
  localparam int CMD_INIT_BIT   = 2;
  localparam int CMD_WRINV_BIT  = 4;
  localparam int CMD_PARITY_BIT = 6;
  localparam int CMD_SERR_BIT   = 8;
  localparam int CMD_BLOCK_BIT  = 10;

  localparam logic [15:0] CMD_RESET   = 16'h0000;
  localparam logic [15:0] CMD_WR_MASK = 16'h0547;

  // ==========================================================================
  // Status word fields handled here
  // ==========================================================================
  localparam int STS_IRQ_BIT = 3;
  localparam int STS_MDP_BIT = 8;

  // ==========================================================================
  // Identification values (arbitrary, not tied to any real part)
  // ==========================================================================
  localparam logic [15:0] VENDOR_IDENT_DEFAULT = 16'h1A2B;
  localparam logic [15:0] DEVICE_IDENT_F0      = 16'h3C4D;
  localparam logic [15:0] DEVICE_IDENT_F2      = 16'h3C4E;

endpackage : bhc_pkg

/* File: hw/bhc_gate.sv */
// Gating of error reports, initiator requests and target decodes by the command word.
`timescale 1ns/100ps
`default_nettype none

module bhc_gate (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] command_control_word,
  input  wire logic        serr_event,
  input  wire logic        cpl_parity_err,
  input  wire logic        tgt_mem_req,
  input  wire logic        tgt_io_req,
  input  wire logic        mst_req,
  output logic             serr_report,
  output logic             parity_report,
  output logic             tgt_mem_accept,
  output logic             tgt_io_accept,
  output logic             tgt_master_abort,
  output logic             mst_grant
);

  logic serr_reg, serr_next;
  logic par_reg, par_next;
  logic mem_acc_reg, mem_acc_next;
  logic io_acc_reg, io_acc_next;
  logic abort_reg, abort_next;

  // ==========================================================================
  // Gating
  // ==========================================================================
  always_comb begin
    serr_next    = serr_event && command_control_word[bhc_pkg::CMD_SERR_BIT];     // R4
    par_next     = cpl_parity_err && command_control_word[bhc_pkg::CMD_PARITY_BIT];  // R5
    mem_acc_next = tgt_mem_req && command_control_word[bhc_pkg::CMD_MEM_BIT];     // R7
    io_acc_next  = tgt_io_req && command_control_word[bhc_pkg::CMD_IO_BIT];       // R8
    abort_next   = (tgt_mem_req && !command_control_word[bhc_pkg::CMD_MEM_BIT])
                || (tgt_io_req && !command_control_word[bhc_pkg::CMD_IO_BIT]);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serr_reg    <= 1'b0;
      par_reg     <= 1'b0;
      mem_acc_reg <= 1'b0;
      io_acc_reg  <= 1'b0;
      abort_reg   <= 1'b0;
    end else begin
      serr_reg    <= serr_next;
      par_reg     <= par_next;
      mem_acc_reg <= mem_acc_next;
      io_acc_reg  <= io_acc_next;
      abort_reg   <= abort_next;
    end
  end

  assign serr_report      = serr_reg;
  assign parity_report    = par_reg;
  assign tgt_mem_accept   = mem_acc_reg;
  assign tgt_io_accept    = io_acc_reg;
  assign tgt_master_abort = abort_reg;
  // The grant is combinational so a request stalls the same cycle mastering is turned off.
  assign mst_grant = mst_req && command_control_word[bhc_pkg::CMD_INIT_BIT];  // R6

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking gate_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  serr_gate_a: assert property (serr_report |-> $past(serr_event)  // R4
      && $past(command_control_word[bhc_pkg::CMD_SERR_BIT]))
    else $error("system error reported while reporting disabled");
  parity_gate_a: assert property (cpl_parity_err  // R5
      && !command_control_word[bhc_pkg::CMD_PARITY_BIT] |=> !parity_report)
    else $error("parity error reported while response disabled");
  init_gate_a: assert property (mst_grant |-> mst_req  // R6
      && command_control_word[bhc_pkg::CMD_INIT_BIT])
    else $error("request granted while initiator disabled");
  mem_abort_a: assert property (tgt_mem_req && !tgt_io_req  // R7
      && !command_control_word[bhc_pkg::CMD_MEM_BIT] |=> tgt_master_abort && !tgt_mem_accept)
    else $error("memory request not master aborted");
  io_abort_a: assert property (tgt_io_req && !tgt_mem_req  // R8
      && !command_control_word[bhc_pkg::CMD_IO_BIT] |=> tgt_master_abort && !tgt_io_accept)
    else $error("io request not master aborted");
  io_accept_a: assert property (tgt_io_req  // R8
      && command_control_word[bhc_pkg::CMD_IO_BIT] |=> tgt_io_accept)
    else $error("io request not accepted");

endmodule : bhc_gate

`default_nettype wire

/* File: hw/bhc_config_header.sv */
// Bridge configuration header: identification words, command word and wired hot-plug interrupt.
//
// Notes on behaviour
// R1 - Block bit set stops wired hot-plug interrupt.
// R2 - Block bit matters only while MSI disabled.
// R3 - Setting block bit drops an asserted interrupt.
// R4 - System error enable gates SERR reporting.
// R5 - Parity response enable gates completion parity reports.
// R6 - Initiator enable permits issuing memory/IO requests.
// R7 - Memory enable off master-aborts memory requests.
// R8 - IO enable off master-aborts IO requests.
// R9 - Reserved command bits read zero, ignore writes.
// R10 - Never write-and-invalidate; that bit reads zero.
// R11 - Fixed read-only vendor word at 00h.
// R12 - Read-only device word at 02h, per function.
// R13 - Command word 16 bits at 04h, resets zero.
// R14 - Interrupt only if unblocked, MSI off, status set.
// R15 - Completion parity error sets master parity flag.
// R16 - Identification writes ignored, reads have no effects.
`timescale 1ns/100ps
`default_nettype none

module bhc_config_header #(
  parameter logic [15:0] VENDOR_IDENT = bhc_pkg::VENDOR_IDENT_DEFAULT,
  parameter logic [15:0] DEVICE_F0    = bhc_pkg::DEVICE_IDENT_F0,
  parameter logic [15:0] DEVICE_F2    = bhc_pkg::DEVICE_IDENT_F2
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        function_two_strap,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_ack,
  input  wire logic        msi_enable,
  input  wire logic        hp_irq_status,
  output logic             hp_irq_wired_n,
  input  wire logic        serr_event,
  input  wire logic        cpl_parity_err,
  output logic             serr_report,
  output logic             parity_report,
  input  wire logic        tgt_mem_req,
  input  wire logic        tgt_io_req,
  output logic             tgt_mem_accept,
  output logic             tgt_io_accept,
  output logic             tgt_master_abort,
  input  wire logic        mst_req,
  output logic             mst_grant
);

  logic [15:0] cmd_reg, cmd_next;
  logic        mdp_reg, mdp_next;
  logic        irq_n_reg, irq_n_next;
  logic        func2_reg, func2_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic [15:0] device_ident_value;
  logic [15:0] status_word;
  logic        wr_cmd_dword;

  // Byte-lane merge of a 16-bit word under two enables, limited to writable bits.
  function automatic logic [15:0] merge_word(input logic [15:0] old_w,
                                             input logic [15:0] new_w,
                                             input logic [1:0]  be,
                                             input logic [15:0] mask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge_word = (old_w & ~lane) | (new_w & lane);
  endfunction : merge_word

  // Dword index of a byte offset.
  function automatic logic [5:0] dword_of(input logic [7:0] ofs);
    dword_of = ofs[7:2];
  endfunction : dword_of

  // ==========================================================================
  // Identification
  // ==========================================================================
  assign device_ident_value = func2_reg ? DEVICE_F2 : DEVICE_F0;  // R12
  assign status_word = (16'h0001 << bhc_pkg::STS_IRQ_BIT) & {16{hp_irq_status}}
                     | (16'h0001 << bhc_pkg::STS_MDP_BIT) & {16{mdp_reg}};
  assign wr_cmd_dword = cfg_req && cfg_we
                     && (dword_of(cfg_addr) == dword_of(bhc_pkg::OFS_COMMAND));

  // ==========================================================================
  // Command, status flag, interrupt and configuration read path
  // ==========================================================================
  always_comb begin
    func2_next = func2_reg;
    cmd_next   = cmd_reg;
    mdp_next   = mdp_reg;
    if (wr_cmd_dword) begin
      cmd_next = merge_word(cmd_reg, cfg_wdata[15:0], cfg_be[1:0],
                            bhc_pkg::CMD_WR_MASK);  // R9 R10 R13
      if (cfg_be[3] && cfg_wdata[16 + bhc_pkg::STS_MDP_BIT]) begin
        mdp_next = 1'b0;
      end
    end
    // A parity event in the clearing cycle wins over the clear.
    if (cpl_parity_err && cmd_reg[bhc_pkg::CMD_PARITY_BIT]) begin
      mdp_next = 1'b1;  // R15
    end
    // The next command value is used so the line drops with the write that sets the block.
    irq_n_next = !(hp_irq_status && !msi_enable
                   && !cmd_next[bhc_pkg::CMD_BLOCK_BIT]);  // R1 R2 R3 R14
    ack_next   = cfg_req;
    rdata_next = 32'h0000_0000;
    if (cfg_req && !cfg_we) begin
      case (dword_of(cfg_addr))
        dword_of(bhc_pkg::OFS_VENDOR): begin
          rdata_next = {device_ident_value, VENDOR_IDENT};  // R11 R12 R16
        end
        dword_of(bhc_pkg::OFS_COMMAND): begin
          rdata_next = {status_word, cmd_reg};
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      func2_reg <= function_two_strap;
      cmd_reg   <= bhc_pkg::CMD_RESET;  // R13
      mdp_reg   <= 1'b0;
      irq_n_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
    end else begin
      func2_reg <= func2_next;
      cmd_reg   <= cmd_next;
      mdp_reg   <= mdp_next;
      irq_n_reg <= irq_n_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  assign cfg_rdata      = rdata_reg;
  assign cfg_ack        = ack_reg;
  assign hp_irq_wired_n = irq_n_reg;

  // ==========================================================================
  // Gating of transactions
  // ==========================================================================
  bhc_gate u_gate (
    .sys_clk              (sys_clk),
    .sys_rst              (sys_rst),
    .command_control_word (cmd_reg),
    .serr_event           (serr_event),
    .cpl_parity_err       (cpl_parity_err),
    .tgt_mem_req          (tgt_mem_req),
    .tgt_io_req           (tgt_io_req),
    .mst_req              (mst_req),
    .serr_report          (serr_report),
    .parity_report        (parity_report),
    .tgt_mem_accept       (tgt_mem_accept),
    .tgt_io_accept        (tgt_io_accept),
    .tgt_master_abort     (tgt_master_abort),
    .mst_grant            (mst_grant)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking hdr_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence ident_read_s;
    cfg_req && !cfg_we && (cfg_addr[7:2] == 6'h00);
  endsequence

  sequence block_set_s;
    !cmd_reg[bhc_pkg::CMD_BLOCK_BIT] ##1 cmd_reg[bhc_pkg::CMD_BLOCK_BIT];
  endsequence

  sequence mdp_clear_s;
    wr_cmd_dword && cfg_be[3] && cfg_wdata[16 + bhc_pkg::STS_MDP_BIT]
      && !(cpl_parity_err && cmd_reg[bhc_pkg::CMD_PARITY_BIT]);
  endsequence

  cmd_reset_a: assert property (disable iff (1'b0) sys_rst |=> cmd_reg == 16'h0000)  // R13
    else $error("command word not zero after reset");
  irq_block_a: assert property (cmd_reg[bhc_pkg::CMD_BLOCK_BIT] |-> hp_irq_wired_n)  // R1
    else $error("wired interrupt asserted while blocked");
  irq_msi_a: assert property ($past(msi_enable) |-> hp_irq_wired_n)  // R2
    else $error("wired interrupt asserted while message interrupts on");
  irq_drop_a: assert property (block_set_s |-> hp_irq_wired_n)  // R3
    else $error("wired interrupt not dropped when block set");
  irq_cause_a: assert property (!hp_irq_wired_n  // R14
      |-> $past(hp_irq_status) && !$past(msi_enable)
      && !cmd_reg[bhc_pkg::CMD_BLOCK_BIT])
    else $error("wired interrupt asserted without cause");
  irq_raise_a: assert property (hp_irq_status && !msi_enable  // R14
      && !cmd_reg[bhc_pkg::CMD_BLOCK_BIT] && !wr_cmd_dword |=> !hp_irq_wired_n)
    else $error("wired interrupt not asserted");
  rsvd_zero_a: assert property ((cmd_reg & ~bhc_pkg::CMD_WR_MASK) == 16'h0000)  // R9 R10
    else $error("reserved command bit set");
  ident_read_a: assert property (ident_read_s |=> cfg_ack  // R11 R12 R16
      && cfg_rdata == {device_ident_value, VENDOR_IDENT})
    else $error("identification read wrong");
  mdp_set_a: assert property (cpl_parity_err  // R15
      && cmd_reg[bhc_pkg::CMD_PARITY_BIT] |=> mdp_reg)
    else $error("master parity flag not set");
  mdp_clear_a: assert property (mdp_clear_s |=> !mdp_reg)  // R15
    else $error("master parity flag not cleared");
  wrinv_zero_a: assert property (!cmd_reg[bhc_pkg::CMD_WRINV_BIT])  // R10
    else $error("write and invalidate bit set");
  write_ack_a: assert property (cfg_req && cfg_we |=> cfg_ack && cfg_rdata == 32'h0)  // R16
    else $error("write not acknowledged with zero data");
  read_quiet_a: assert property (cfg_req && !cfg_we |=> $stable(cmd_reg))  // R16
    else $error("command word changed by a read");
  cmd_read_a: assert property (cfg_req && !cfg_we  // R13
      && cfg_addr[7:2] == 6'h01 |=> cfg_rdata[15:0] == $past(cmd_reg))
    else $error("command word read wrong");
  func2_hold_a: assert property (!sys_rst |=> $stable(func2_reg))  // R12
    else $error("function strap changed outside reset");

endmodule : bhc_config_header

`default_nettype wire

/* File: verif/bhc_upstream_model.sv */
// Upstream port model that issues configuration accesses and request events.
`timescale 1ns/100ps
`default_nettype none

module bhc_upstream_model (
  input  wire logic        sys_clk,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  output logic [3:0]       req_events
);
  // ==========================================================================
  // Idle levels and request tasks
  // ==========================================================================
  initial begin
    cfg_req    = 1'b0;
    cfg_we     = 1'b0;
    cfg_addr   = 8'h00;
    cfg_be     = 4'h0;
    cfg_wdata  = 32'h0;
    req_events = 4'h0;
  end

  // Released lines show inverted data so stale values are never mistaken for live ones.
  task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] wd);
    @(posedge sys_clk);
    cfg_req   <= 1'b1;
    cfg_we    <= we;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= wd;
    @(posedge sys_clk);
    cfg_req   <= 1'b0;
    cfg_we    <= ~we;
    cfg_addr  <= ~a;
    cfg_be    <= ~be;
    cfg_wdata <= ~wd;
  endtask : access

  task automatic fire(input logic [3:0] e);
    @(posedge sys_clk);
    req_events <= e;
    @(posedge sys_clk);
    req_events <= 4'h0;
  endtask : fire

endmodule : bhc_upstream_model
`default_nettype wire

/* File: verif/bridge_config_header_command_tb_top.sv */
// Self-checking bench for the bridge configuration header block.
`timescale 1ns/100ps
`default_nettype none

module bridge_config_header_command_tb_top;
  localparam logic [15:0] CMDS [4] = '{16'h0000, 16'h0547, 16'h0145, 16'h0142};
  logic        sys_clk;
  logic        sys_rst = 1'b1;
  logic        strap = 1'b0;
  logic        msi = 1'b0;
  logic        hpst = 1'b0;
  logic        mst_req = 1'b0;
  logic        cfg_req;
  logic        cfg_we;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic [3:0]  ev;
  logic [31:0] cfg_rdata;
  logic        cfg_ack;
  logic        irq_n;
  logic        serr_rep;
  logic        par_rep;
  logic        mem_acc;
  logic        io_acc;
  logic        abort;
  logic        grant;
  logic        ev_seen = 1'b0;
  logic [15:0] cmd = 16'h0;
  logic        mdp = 1'b0;
  logic [31:0] q_rd[$];
  logic [31:0] q_ev[$];
  int          miscompares = 0;
  int          n_checks = 0;

  bhc_upstream_model u_up (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .req_events(ev));

  bhc_config_header u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .function_two_strap(strap), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .msi_enable(msi), .hp_irq_status(hpst), .hp_irq_wired_n(irq_n), .serr_event(ev[3]),
    .cpl_parity_err(ev[2]), .serr_report(serr_rep), .parity_report(par_rep),
    .tgt_mem_req(ev[1]), .tgt_io_req(ev[0]), .tgt_mem_accept(mem_acc),
    .tgt_io_accept(io_acc), .tgt_master_abort(abort), .mst_req(mst_req), .mst_grant(grant));

  // ==========================================================================
  // Clock, scoreboard and closing
  // ==========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge sys_clk) ev_seen <= |ev;

  always @(negedge sys_clk) begin
    if (cfg_ack === 1'b1) chk(cfg_rdata, q_rd.size() > 0 ? q_rd.pop_front() : 32'hFFFFFFFF);
    if (ev_seen) chk({27'h0, serr_rep, par_rep, mem_acc, io_acc, abort}, q_ev.pop_front());
  end

  // ==========================================================================
  // Drivers that note expected results
  // ==========================================================================
  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    strap   <= s;
    cmd = 16'h0;
    mdp = 1'b0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & bhc_pkg::CMD_WR_MASK;
    if (a[7:2] == 6'h01) begin
      cmd = (cmd & ~m) | (w[15:0] & m);
      if (be[3] && w[24]) mdp = 1'b0;
    end
    q_rd.push_back(32'h0);
    u_up.access(1'b1, a, be, w);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = 32'h0;
    if (a[7:2] == 6'h00) e = {strap ? bhc_pkg::DEVICE_IDENT_F2 : bhc_pkg::DEVICE_IDENT_F0,
                              bhc_pkg::VENDOR_IDENT_DEFAULT};
    if (a[7:2] == 6'h01) e = {7'h00, mdp, 4'h0, hpst, 3'h0, cmd};
    q_rd.push_back(e);
    u_up.access(1'b0, a, 4'hF, 32'h0);
  endtask : rd

  task automatic fire(input logic [3:0] e);
    if (e[2] && cmd[6]) mdp = 1'b1;
    q_ev.push_back({27'h0, e[3] & cmd[8], e[2] & cmd[6], e[1] & cmd[1], e[0] & cmd[0],
                    (e[1] & ~cmd[1]) | (e[0] & ~cmd[0])});
    u_up.fire(e);
  endtask : fire

  task automatic lvl();
    logic [31:0] e;
    @(negedge sys_clk);
    e = {30'h0, ~(hpst & ~msi & ~cmd[10]), mst_req & cmd[2]};
    chk({30'h0, irq_n, grant}, e);
  endtask : lvl

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    void'($urandom(32'hC796F113));
    do_reset(1'b0);
    rd(8'h00);
    rd(8'h04);
    rd(8'h08);
    wr(8'h00, 4'hF, $urandom());
    rd(8'h00);
    repeat (8) begin
      wr(8'h04, 4'($urandom()), $urandom());
      rd(8'h04);
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 4'h3, {16'h0, CMDS[c]});
      for (int e = 1; e < 16; e++) fire(4'(e));
      rd(8'h04);
      mst_req <= ~mst_req;
      lvl();
    end
    wr(8'h04, 4'h8, 32'h01000000);
    rd(8'h04);
    $display("test gating done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 4'h2, {21'h0, i[0], 10'h0});
      lvl();
      @(posedge sys_clk);
      msi  <= i[1];
      hpst <= i[2];
      repeat (2) @(posedge sys_clk);
      lvl();
      rd(8'h04);
    end
    $display("test interrupt done");
    do_reset(1'b1);
    rd(8'h00);
    rd(8'h04);
    repeat (3) @(posedge sys_clk);
    $display("test strap done");
    if (q_rd.size() + q_ev.size() != 0) miscompares++;
    end_sim();
  end

  // About 250 cycles are needed; the limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

endmodule : bridge_config_header_command_tb_top
`default_nettype wire
